// ===== mon_seq_pkg.sv
`default_nettype none
package mon_seq_pkg;
   // =========================================
   // register byte offsets
   localparam logic [7:0] cfg_off = 8'h00;
   localparam logic [7:0] status_off = 8'h04;
   localparam logic [7:0] shunt_off = 8'h08;
   localparam logic [7:0] bus_off = 8'h0C;
   localparam logic [7:0] power_off = 8'h10;
   localparam logic [7:0] current_off = 8'h14;
   localparam logic [7:0] calib_off = 8'h18;
   // =========================================
   // field positions and reset values
   localparam int reset_bit = 15;
   localparam logic [15:0] cfg_reset = 16'h399F;
   localparam int done_bit = 1;
   localparam int math_bit = 0;
   localparam int recover_bit = 2;
   localparam int cal_frac = 12;
   // =========================================
   // timing
   localparam int clk_mhz = 25;
   localparam int recover_us = 40;
   localparam int recover_cycles = recover_us * clk_mhz;
   localparam int conv_base_us = 84;
   localparam int conv_base_cycles = conv_base_us * clk_mhz;
   // =========================================
   // full-scale limits in result counts
   localparam logic [15:0] shunt_fs_base = 16'h0FA0;
   localparam logic [12:0] bus_fs_16v = 13'h0FA0;
   localparam logic [12:0] bus_fs_32v = 13'h1F40;
   // =========================================
   // types
   typedef enum logic [2:0] {
      mode_pd = 3'b000, mode_shunt_trig = 3'b001, mode_bus_trig = 3'b010, mode_both_trig = 3'b011,
      mode_off = 3'b100, mode_shunt_cont = 3'b101, mode_bus_cont = 3'b110, mode_both_cont = 3'b111
   } mode_e;
   typedef enum logic [1:0] {
      st_idle = 2'b00, st_recover = 2'b01, st_shunt = 2'b10, st_bus = 2'b11
   } state_e;
   typedef struct packed {
      logic rst;
      logic spare;
      logic bus_range;
      logic [1:0] shunt_gain_setting;
      logic [3:0] bus_average_field;
      logic [3:0] shunt_average_field;
      logic [2:0] mode;
   } cfg_s;
endpackage : mon_seq_pkg
`default_nettype wire

// ===== monitor_conversion_sequencer.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none
// How it works
// (R1) soft reset bit or general call reset restores every power-up value
// (R2) mode 111 converts shunt samples, then bus samples, and repeats
// (R3) other modes convert one channel or both, continuous or triggered
// (R4) current and power math overlaps the next conversion cycle
// (R5) power-down halts conversions; 40 us recovery wait on leaving it
// (R6) converter-off halts conversions until another mode is written
// (R7) every write of a triggered mode starts exactly one single shot
// (R8) results stay readable and hold until a newer cycle replaces them
// (R9) done flag sets only after conversions, averaging and math finish
// (R10) config write clears done flag unless mode is power-down or off
// (R11) reading status clears the done flag
// (R12) convert input starting a single shot clears the done flag
// (R13) shunt and bus sampled at separate times, long gaps at deep averaging
// (R14) shunt gain selects 40 mV full scale times 1, 2, 4 or 8
// (R15) bus range selects 16 V or 32 V full scale
// (R16) resolution and averaging set separately per channel
// (R17) reset defaults: 12-bit, 320 mV, 32 V, continuous both channels
// (R18) current and power only produced with nonzero calibration
// (R19) bus result weight fixed at 4 mV per count
// (R20) soft reset bit clears itself and reads back zero
// (R21) triggered cycle done: converter idles until the next trigger
module monitor_conversion_sequencer #(
   parameter int conv_base = mon_seq_pkg::conv_base_cycles
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial bus and convert pin events
   input wire logic general_call_reset,
   input wire logic convert_start,
   // converter sample codes
   input wire logic [15:0] shunt_code,
   input wire logic [12:0] bus_code,
   // status pins
   output logic conversion_done,
   output logic converting
);
   // =========================================
   // per-channel setting decode
   function automatic logic [2:0] avg_shift(input logic [3:0] f);
      avg_shift = f[3] ? f[2:0] : 3'h0;
   endfunction : avg_shift

   function automatic logic [15:0] conv_len(input logic [3:0] f);
      logic [1:0] r;
      r = f[3] ? 2'h3 : f[1:0];
      conv_len = 16'((conv_base << r) - 1);
   endfunction : conv_len

   function automatic logic [7:0] last_samp(input logic [2:0] s);
      last_samp = 8'((9'h001 << s) - 9'h001);
   endfunction : last_samp

   // =========================================
   // state
   mon_seq_pkg::cfg_s cfg;
   mon_seq_pkg::state_e state;
   mon_seq_pkg::state_e next_state;
   logic [15:0] calib;
   logic [15:0] shunt_res;
   logic [12:0] bus_res;
   logic [15:0] current_res;
   logic [15:0] power_res;
   logic [15:0] cnt;
   logic [7:0] nsamp;
   logic signed [23:0] acc;
   logic [9:0] rec_cnt;
   logic pending;
   logic math_go;
   logic flag;

   // =========================================
   // apb decode
   wire logic done_acc = psel & penable & pready;
   wire logic wr = done_acc & pwrite;
   wire logic rd = done_acc & ~pwrite;
   wire logic mapped = (paddr == mon_seq_pkg::cfg_off) | (paddr == mon_seq_pkg::status_off) |
                       (paddr == mon_seq_pkg::shunt_off) | (paddr == mon_seq_pkg::bus_off) |
                       (paddr == mon_seq_pkg::power_off) | (paddr == mon_seq_pkg::current_off) |
                       (paddr == mon_seq_pkg::calib_off);
   wire logic cfg_wr = wr & (paddr == mon_seq_pkg::cfg_off);
   wire logic cal_wr = wr & (paddr == mon_seq_pkg::calib_off);
   wire logic stat_rd = rd & (paddr == mon_seq_pkg::status_off);
   wire mon_seq_pkg::cfg_s wcfg = mon_seq_pkg::cfg_s'(pwdata[15:0]);
   wire logic soft_rst = (cfg_wr & pwdata[mon_seq_pkg::reset_bit]) | general_call_reset;  // R1
   wire logic w_idle = (wcfg.mode[1:0] == 2'b00);
   wire logic trig_wr = cfg_wr & ~soft_rst & ~wcfg.mode[2] & ~w_idle;  // R7
   wire logic cfg_trig = ~cfg.mode[2] & (cfg.mode[1:0] != 2'b00);
   wire logic pin_trig = convert_start & cfg_trig & ~cfg_wr & ~soft_rst;
   wire logic leave_pd = cfg_wr & ~soft_rst & (cfg.mode == mon_seq_pkg::mode_pd) &
                         (wcfg.mode != mon_seq_pkg::mode_pd);
   wire logic clr_flag = (cfg_wr & ~w_idle) | stat_rd | pin_trig;  // R10 R11 R12

   // =========================================
   // read mux
   wire logic [15:0] status_val = {13'h0000, (rec_cnt != 10'h000), flag, (calib != 16'h0000)};
   wire logic [15:0] rd_val =
      (paddr == mon_seq_pkg::cfg_off) ? {1'b0, cfg[14:0]} :  // R20
      (paddr == mon_seq_pkg::status_off) ? status_val :
      (paddr == mon_seq_pkg::shunt_off) ? shunt_res :
      (paddr == mon_seq_pkg::bus_off) ? {bus_res, 3'b000} :  // R19
      (paddr == mon_seq_pkg::power_off) ? power_res :
      (paddr == mon_seq_pkg::current_off) ? current_res :
      (paddr == mon_seq_pkg::calib_off) ? calib : 16'h0000;  // R8

   // =========================================
   // sampling and averaging datapath
   wire logic in_shunt = (state == mon_seq_pkg::st_shunt);
   wire logic [2:0] sh_shift = avg_shift(cfg.shunt_average_field);  // R16
   wire logic [2:0] bu_shift = avg_shift(cfg.bus_average_field);  // R16
   wire logic [2:0] cur_shift = in_shunt ? sh_shift : bu_shift;
   wire logic signed [23:0] samp = in_shunt ? {{8{shunt_code[15]}}, shunt_code} : {11'h000, bus_code};
   wire logic signed [23:0] avg_sum = acc + samp;
   wire logic signed [23:0] avg_val = avg_sum >>> cur_shift;
   wire logic conv_end = (state == mon_seq_pkg::st_shunt || state == mon_seq_pkg::st_bus) && (cnt == 16'h0000);
   wire logic chan_end = conv_end & (nsamp == last_samp(cur_shift));
   wire logic shunt_end = chan_end & in_shunt;
   wire logic bus_end = chan_end & ~in_shunt;
   wire logic cycle_end = bus_end | (shunt_end & ~cfg.mode[1]);  // R2 R3
   wire logic can_start = (cfg.mode[1:0] != 2'b00) & (rec_cnt == 10'h000) & (cfg.mode[2] | pending);

   // shunt limit scales with gain, bus limit with range
   wire logic signed [15:0] sh_lim = 16'(mon_seq_pkg::shunt_fs_base << cfg.shunt_gain_setting);  // R14
   wire logic signed [15:0] sh_avg = avg_val[15:0];
   wire logic [15:0] sh_sat = (sh_avg > sh_lim) ? sh_lim : (sh_avg < -sh_lim) ? -sh_lim : sh_avg;  // R14
   wire logic [12:0] bu_lim = cfg.bus_range ? mon_seq_pkg::bus_fs_32v : mon_seq_pkg::bus_fs_16v;  // R15
   wire logic [12:0] bu_sat = (avg_val[12:0] > bu_lim) ? bu_lim : avg_val[12:0];  // R15

   // background math from held results
   wire logic signed [31:0] cur_prod = $signed(shunt_res) * $signed(calib);
   wire logic [15:0] next_current = cur_prod[mon_seq_pkg::cal_frac +: 16];
   wire logic signed [32:0] pow_prod = $signed(next_current) * $signed({4'h0, bus_res});
   wire logic [15:0] next_power = pow_prod[mon_seq_pkg::cal_frac +: 16];

   // =========================================
   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         mon_seq_pkg::st_idle: begin
            if (can_start) begin
               next_state = cfg.mode[0] ? mon_seq_pkg::st_shunt : mon_seq_pkg::st_bus;  // R2 R3 R21
            end
         end
         mon_seq_pkg::st_recover: begin
            if (rec_cnt == 10'h000) begin
               next_state = mon_seq_pkg::st_idle;
            end
         end
         mon_seq_pkg::st_shunt: begin
            if (shunt_end) begin
               next_state = cfg.mode[1] ? mon_seq_pkg::st_bus : mon_seq_pkg::st_idle;  // R13
            end
         end
         mon_seq_pkg::st_bus: begin
            if (bus_end) begin
               next_state = mon_seq_pkg::st_idle;
            end
         end
         default: begin
            next_state = mon_seq_pkg::st_idle;
         end
      endcase
   end

   // =========================================
   // apb answer, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata <= {16'h0000, rd_val};
            pslverr <= ~mapped;
         end
      end
   end

   // =========================================
   // configuration and calibration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= mon_seq_pkg::cfg_s'(mon_seq_pkg::cfg_reset);  // R17
         calib <= 16'h0000;
      end else if (soft_rst) begin
         cfg <= mon_seq_pkg::cfg_s'(mon_seq_pkg::cfg_reset);  // R1 R17
         calib <= 16'h0000;
      end else begin
         if (cfg_wr) begin
            cfg <= {1'b0, wcfg[14:0]};  // R20
         end
         if (cal_wr) begin
            calib <= pwdata[15:0];
         end
      end
   end

   // =========================================
   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= mon_seq_pkg::st_idle;
         cnt <= 16'h0000;
         nsamp <= 8'h00;
         acc <= 24'sh000000;
         rec_cnt <= 10'h000;
         pending <= 1'b0;
      end else if (soft_rst) begin
         state <= mon_seq_pkg::st_idle;
         cnt <= 16'h0000;
         nsamp <= 8'h00;
         acc <= 24'sh000000;
         rec_cnt <= 10'h000;
         pending <= 1'b0;
      end else if (cfg_wr) begin
         // any config write restarts the cycle under the new settings
         state <= leave_pd ? mon_seq_pkg::st_recover : mon_seq_pkg::st_idle;  // R5 R6
         rec_cnt <= leave_pd ? 10'(mon_seq_pkg::recover_cycles - 1) : 10'h000;  // R5
         pending <= trig_wr;  // R7
         nsamp <= 8'h00;
         acc <= 24'sh000000;
      end else begin
         state <= next_state;
         if (rec_cnt != 10'h000) begin
            rec_cnt <= rec_cnt - 10'h001;
         end
         if (pin_trig) begin
            pending <= 1'b1;
         end else if (state == mon_seq_pkg::st_idle && can_start) begin
            pending <= 1'b0;  // R21
         end
         if (state == mon_seq_pkg::st_idle && can_start) begin
            cnt <= conv_len(cfg.mode[0] ? cfg.shunt_average_field : cfg.bus_average_field);
         end else if (conv_end) begin
            cnt <= chan_end ? conv_len(cfg.bus_average_field) : conv_len(in_shunt ?  // R13
                   cfg.shunt_average_field : cfg.bus_average_field);
            nsamp <= chan_end ? 8'h00 : nsamp + 8'h01;
            acc <= chan_end ? 24'sh000000 : avg_sum;
         end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end
      end
   end

   // =========================================
   // results, math and done flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shunt_res <= 16'h0000;
         bus_res <= 13'h0000;
         current_res <= 16'h0000;
         power_res <= 16'h0000;
         math_go <= 1'b0;
         flag <= 1'b0;
      end else if (soft_rst) begin
         shunt_res <= 16'h0000;
         bus_res <= 13'h0000;
         current_res <= 16'h0000;
         power_res <= 16'h0000;
         math_go <= 1'b0;
         flag <= 1'b0;
      end else begin
         if (shunt_end & ~cfg_wr) begin
            shunt_res <= sh_sat;  // R8
         end
         if (bus_end & ~cfg_wr) begin
            bus_res <= bu_sat;  // R8 R19
         end
         math_go <= cycle_end & ~cfg_wr;  // R4
         if (math_go) begin
            current_res <= (calib != 16'h0000) ? next_current : 16'h0000;  // R18
            power_res <= (calib != 16'h0000) ? next_power : 16'h0000;  // R18
         end
         if (math_go) begin
            flag <= 1'b1;  // R9
         end else if (clr_flag) begin
            flag <= 1'b0;  // R10 R11 R12
         end
      end
   end

   // =========================================
   // status pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_done <= 1'b0;
         converting <= 1'b0;
      end else begin
         conversion_done <= flag;
         converting <= state[1];
      end
   end

   // =========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence finish_s;
      math_go && !cfg_wr && !soft_rst;
   endsequence

   sequence restart_s;
      state != mon_seq_pkg::st_idle;
   endsequence

   soft_reset_cfg_a: assert property (soft_rst |=> cfg == mon_seq_pkg::cfg_reset && !flag)  // R1
      else $error("soft reset did not restore defaults");
   reset_bit_low_a: assert property (!cfg.rst)  // R20
      else $error("reset bit held");
   chan_select_a: assert property ((state == mon_seq_pkg::st_shunt |-> cfg.mode[0]) and  // R3
      (state == mon_seq_pkg::st_bus |-> cfg.mode[1]))
      else $error("channel outside mode");
   shunt_then_bus_a: assert property ((shunt_end && cfg.mode[1] && !cfg_wr && !soft_rst) |=>  // R2
      state == mon_seq_pkg::st_bus)
      else $error("bus did not follow shunt");
   halt_modes_a: assert property ((cfg.mode[1:0] == 2'b00) |-> !state[1])  // R6
      else $error("conversion while halted");
   recover_wait_a: assert property ((leave_pd && !soft_rst) |=>  // R5
      (state == mon_seq_pkg::st_recover && rec_cnt == 10'(mon_seq_pkg::recover_cycles - 1)))
      else $error("recovery wait missing");
   trig_pending_a: assert property ((trig_wr && !soft_rst) |=> pending)  // R7
      else $error("trigger write lost");
   back_to_back_a: assert property ((finish_s and cfg.mode[2] && rec_cnt == 10'h000) |=> restart_s)  // R4
      else $error("math stalled next cycle");
   one_shot_idle_a: assert property ((finish_s and !cfg.mode[2] && !pending && !pin_trig) |=>  // R21
      (state == mon_seq_pkg::st_idle) [*2])
      else $error("triggered mode ran again");
   flag_set_a: assert property (math_go |=> flag)  // R9
      else $error("done flag not set");
   flag_cause_a: assert property ($rose(flag) |-> $past(math_go))  // R9
      else $error("done flag set early");
   flag_clear_a: assert property ((clr_flag && !math_go) |=> !flag)  // R10 R11 R12
      else $error("done flag not cleared");
   result_hold_a: assert property ($changed(shunt_res) |-> $past(shunt_end) || $past(soft_rst))  // R8
      else $error("shunt result changed without conversion");
   no_cal_math_a: assert property ((math_go && calib == 16'h0000) |=> current_res == 16'h0000)  // R18
      else $error("current without calibration");
endmodule : monitor_conversion_sequencer
`default_nettype wire

// ===== apb_host_model.sv
`default_nettype none
// =========================================
// host side: apb master with bounded wait
module apb_host_model (
   // clock
   input wire logic pclk,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   bit timed_out = 1'b0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // request held until pready is seen at a rising edge or 16 edges have passed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      timed_out = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// ===== monitor_conversion_sequencer_tb.sv
`default_nettype none
module monitor_conversion_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // =========================================
   // signals
   localparam int cb = 4;
   localparam int one_conv = cb << 3;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic general_call_reset, convert_start, conversion_done, converting;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] shunt_code;
   logic [12:0] bus_code;
   logic e;
   int n_fail = 0;
   int samples_checked = 0;
   int n, sc, bc;
   int seed;
   // =========================================
   // instances
   monitor_conversion_sequencer #(.conv_base(cb)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .general_call_reset(general_call_reset), .convert_start(convert_start),
      .shunt_code(shunt_code), .bus_code(bus_code), .conversion_done(conversion_done), .converting(converting));
   apb_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // =========================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a);
      i_host.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk("pready", 32'h0, {31'h0, i_host.timed_out});
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] dq;
      i_host.xfer(1'b1, a, {16'h0000, d}, dq, e);
      chk("pready", 32'h0, {31'h0, i_host.timed_out});
   endtask : wr
   task automatic wait_done(input int lim, output int cnt);
      cnt = 0;
      repeat (2) @(posedge pclk);
      while (conversion_done !== 1'b1 && cnt < lim) begin
         @(posedge pclk);
         cnt++;
      end
      chk("conversion_done", 32'h1, {31'h0, conversion_done});
   endtask : wait_done
   task automatic count_busy(input int len, output int cnt);
      cnt = 0;
      repeat (len) begin
         @(posedge pclk);
         if (converting !== 1'b0) cnt++;
      end
   endtask : count_busy
   function automatic logic [31:0] exp_shunt(input int c, input int g);
      int lim;
      lim = int'(mon_seq_pkg::shunt_fs_base) << g;
      if (c > lim) c = lim;
      if (c < -lim) c = -lim;
      return {16'h0000, c[15:0]};
   endfunction : exp_shunt
   function automatic logic [31:0] exp_bus(input int c, input logic r);
      int lim;
      lim = r ? int'(mon_seq_pkg::bus_fs_32v) : int'(mon_seq_pkg::bus_fs_16v);
      if (c > lim) c = lim;
      return {16'h0000, c[12:0], 3'b000};
   endfunction : exp_bus
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      wrap_up();
   end
   // =========================================
   // tests
   initial begin
      seed = 32'h5F321CDC;
      presetn = 1'b0;
      general_call_reset = 1'b0;
      convert_start = 1'b0;
      shunt_code = 16'h0000;
      bus_code = 13'h0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(mon_seq_pkg::cfg_off);
      chk("cfg reset", 32'h0000_399F, q);
      rd(mon_seq_pkg::status_off);
      chk("status reset", 32'h0000_0000, q);
      rd(8'h1C);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("test defaults finished");
      for (int i = 0; i < 4; i++) begin
         sc = $random(seed) % 32000;
         bc = {$random(seed)} % 8000;
         shunt_code <= sc[15:0];
         bus_code <= bc[12:0];
         wr(mon_seq_pkg::calib_off, i[0] ? 16'h1000 : 16'h0000);
         wr(mon_seq_pkg::cfg_off, 16'h399F);
         wait_done(400, n);
         chk("cycle length", 32'h1, 32'(n >= 2 * one_conv - 4));
         rd(mon_seq_pkg::status_off);
         chk("status", {30'h0, 1'b1, i[0]}, q);
         rd(mon_seq_pkg::status_off);
         chk("flag after read", 32'h0, {31'h0, q[1]});
         rd(mon_seq_pkg::shunt_off);
         chk("shunt result", exp_shunt(sc, 3), q);
         rd(mon_seq_pkg::bus_off);
         chk("bus result", exp_bus(bc, 1'b1), q);
         rd(mon_seq_pkg::current_off);
         chk("current", i[0] ? exp_shunt(sc, 3) : 32'h0, q);
         rd(mon_seq_pkg::power_off);
         chk("power", i[0] ? (((sc * bc) >>> 12) & 32'h0000_FFFF) : 32'h0, q);
      end
      $display("test continuous data finished");
      for (int g = 0; g < 8; g++) begin
         sc = g[0] ? -32768 : 32767;
         shunt_code <= sc[15:0];
         bus_code <= 13'h1FFF;
         wr(mon_seq_pkg::cfg_off, {2'b00, g[2], g[1:0], 8'h33, 3'b111});
         wait_done(400, n);
         rd(mon_seq_pkg::shunt_off);
         chk("shunt full scale", exp_shunt(sc, g[1:0]), q);
         rd(mon_seq_pkg::bus_off);
         chk("bus full scale", exp_bus(8191, g[2]), q);
      end
      $display("test ranges finished");
      wr(mon_seq_pkg::cfg_off, 16'h399F);
      wait_done(400, n);
      wr(mon_seq_pkg::cfg_off, 16'h3998);
      rd(mon_seq_pkg::status_off);
      chk("flag kept by power-down", 32'h1, {31'h0, q[1]});
      wr(mon_seq_pkg::cfg_off, 16'h3999);
      rd(mon_seq_pkg::status_off);
      chk("recovering and cleared", 32'h5, {29'h0, q[2:0]});
      n = 0;
      while (converting !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk("recovery wait", 32'h1, 32'(n >= mon_seq_pkg::recover_cycles - 12 && n < 3000));
      wait_done(400, n);
      count_busy(100, n);
      chk("idle after shot", 32'h0, n);
      wr(mon_seq_pkg::cfg_off, 16'h3999);
      wait_done(400, n);
      @(posedge pclk);
      convert_start <= 1'b1;
      @(posedge pclk);
      convert_start <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("flag cleared by pin", 32'h0, {31'h0, conversion_done});
      wait_done(400, n);
      wr(mon_seq_pkg::cfg_off, 16'h399C);
      repeat (3) @(posedge pclk);
      chk("flag kept by off", 32'h1, {31'h0, conversion_done});
      count_busy(200, n);
      chk("off mode busy", 32'h0, n);
      sc = $random(seed) % 1000;
      bc = {$random(seed)} % 4000;
      shunt_code <= sc[15:0];
      bus_code <= bc[12:0];
      wr(mon_seq_pkg::cfg_off, 16'h3C83);
      wait_done(400, n);
      chk("averaged cycle", 32'(cb + 2 * one_conv + 2), 32'(n));
      rd(mon_seq_pkg::shunt_off);
      chk("shunt one sample", exp_shunt(sc, 3), q);
      rd(mon_seq_pkg::bus_off);
      chk("bus two samples", exp_bus(bc, 1'b1), q);
      $display("test modes finished");
      wr(mon_seq_pkg::calib_off, 16'h1234);
      wr(mon_seq_pkg::cfg_off, 16'h8000);
      rd(mon_seq_pkg::cfg_off);
      chk("cfg after soft reset", 32'h0000_399F, q);
      rd(mon_seq_pkg::calib_off);
      chk("calib after soft reset", 32'h0, q);
      wr(mon_seq_pkg::cfg_off, 16'h2047);
      @(posedge pclk);
      general_call_reset <= 1'b1;
      @(posedge pclk);
      general_call_reset <= 1'b0;
      rd(mon_seq_pkg::cfg_off);
      chk("cfg after call reset", 32'h0000_399F, q);
      $display("test resets finished");
      wrap_up();
   end
endmodule : monitor_conversion_sequencer_tb
`default_nettype wire
